// file: rtl/scu_pkg.sv
package scu_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int PC_W = 13;
	localparam int SP_W = 8;
	localparam int DATA_W = 8;
	localparam int DEPTH = 16;

	// ==========================================================
	// Operations decoded ahead of this block
	// ==========================================================
	typedef enum logic [3:0] {
		SCU_OP_NOP,
		SCU_OP_CALL,
		SCU_OP_GOTO,
		SCU_OP_RET_IMM,
		SCU_OP_RET,
		SCU_OP_RETI,
		SCU_OP_WDCLR,
		SCU_OP_PCADD,
		SCU_OP_GIE_SET,
		SCU_OP_GIE_CLR,
		SCU_OP_FULL_HALT,
		SCU_OP_CORE_HALT,
		SCU_OP_SW_RESET
	} scu_op_t;

	// ==========================================================
	// Reset values and step constants
	// ==========================================================
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [SP_W-1:0] SP_RESET = 8'h00;
	localparam logic [SP_W-1:0] SP_STEP = 8'h02;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage

// file: rtl/scu_stack_mem.sv
`timescale 1ns/100ps
// Two-byte return-address entries; read data comes out of a register.
module scu_stack_mem #(
	parameter int ENTRIES = 16,
	parameter int WIDTH = 13
) (
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [$clog2(ENTRIES)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(ENTRIES)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [ENTRIES];

	// ==========================================================
	// Storage
	// ==========================================================
	// Write and registered read in one process; no reset is needed.
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // scu_stack_mem

// file: rtl/scu_system_control.sv
`timescale 1ns/100ps
// What this block does
// - Call pushes pc+1 at stack_pointer, jumps anywhere, adds two to pointer.
// - Jump loads any program address and leaves the stack alone.
// - Return-with-value loads immediate into accumulator, then returns normally.
// - Return subtracts two from stack_pointer, then reloads pc from stack.
// - Interrupt return acts like return, then sets global interrupt enable.
// - Watchdog clear pulses the watchdog reset, steps pc by one, and changes nothing else.
// - Relative jump sets pc to pc plus unsigned accumulator.
// - Enable instruction sets the global interrupt enable.
// - Disable instruction clears the global interrupt enable.
// - Full halt stops all clocks including the oscillators.
// - Core halt gates the system clock but keeps oscillators running.
// - Software reset requests a whole-chip reset like hardware reset.
// - No instruction here changes zero, carry, auxiliary or overflow flags.
// - Flow-changing instructions take two cycles, all others one.
module scu_system_control #(
	parameter int PC_W = scu_pkg::PC_W,
	parameter int DEPTH = scu_pkg::DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic op_valid,
	input wire scu_pkg::scu_op_t op_code,
	input wire logic [PC_W-1:0] op_target,
	input wire logic [scu_pkg::DATA_W-1:0] op_imm,
	input wire logic [scu_pkg::DATA_W-1:0] acc_in,
	input wire logic [3:0] flags_in,
	output logic op_ready,
	output logic op_done,
	output logic [PC_W-1:0] pc,
	output logic [scu_pkg::SP_W-1:0] stack_pointer,
	output logic [scu_pkg::DATA_W-1:0] acc_out,
	output logic acc_we,
	output logic [3:0] flags_out,
	output logic gie,
	output logic wdt_clear,
	output logic full_halt,
	output logic core_halt,
	output logic sw_reset_req
);

	localparam int AW = $clog2(DEPTH);

	typedef enum logic [1:0] {
		SCU_ST_IDLE,
		SCU_ST_SECOND,
		SCU_ST_HALT
	} scu_state_t;

	scu_state_t state_reg, state_next;
	scu_pkg::scu_op_t op_reg, op_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [PC_W-1:0] tgt_reg, tgt_next;
	logic [scu_pkg::SP_W-1:0] sp_reg, sp_next;
	logic [scu_pkg::DATA_W-1:0] acc_reg, acc_next;
	logic acc_we_reg, acc_we_next;
	logic gie_reg, gie_next;
	logic wdt_reg, wdt_next;
	logic full_reg, full_next;
	logic core_reg, core_next;
	logic swr_reg, swr_next;
	logic done_reg, done_next;
	logic ready_reg, ready_next;
	logic [3:0] flags_reg;
	logic mem_we;
	logic [AW-1:0] mem_waddr, mem_raddr;
	logic [PC_W-1:0] mem_rdata;

	// ==========================================================
	// Helpers
	// ==========================================================
	// Stack pointer counts bytes; an entry is two bytes, so drop bit 0.
	function automatic logic [AW-1:0] entry_of(
		input logic [scu_pkg::SP_W-1:0] p
	);
		entry_of = p[AW:1];
	endfunction

	function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] p);
		pc_inc = PC_W'(p + scu_pkg::PC_STEP);
	endfunction

	// ==========================================================
	// Stack memory
	// ==========================================================
	scu_stack_mem #(
		.ENTRIES(DEPTH),
		.WIDTH(PC_W)
	) i_scu_stack_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(pc_inc(pc_reg)),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	// Call writes at the current pointer; a return reads below it.
	assign mem_we = op_valid && ready_reg &&
		op_code == scu_pkg::SCU_OP_CALL;
	assign mem_waddr = entry_of(sp_reg);
	assign mem_raddr = entry_of(
		scu_pkg::SP_W'(sp_reg - scu_pkg::SP_STEP));

	// ==========================================================
	// Sequencer
	// ==========================================================
	// The second cycle of a return uses the registered memory read, which
	// is why flow changes cost two cycles rather than a faster bypass.
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		pc_next = pc_reg;
		tgt_next = tgt_reg;
		sp_next = sp_reg;
		acc_next = acc_reg;
		acc_we_next = 1'b0;
		gie_next = gie_reg;
		wdt_next = 1'b0;
		full_next = full_reg;
		core_next = core_reg;
		swr_next = 1'b0;
		done_next = 1'b0;
		ready_next = ready_reg;
		unique case (state_reg)
			SCU_ST_IDLE: begin
				if (op_valid) begin
					op_next = op_code;
					unique case (op_code)
						scu_pkg::SCU_OP_CALL, scu_pkg::SCU_OP_GOTO: begin
							tgt_next = op_target;
							state_next = SCU_ST_SECOND;
							ready_next = 1'b0;
						end
						scu_pkg::SCU_OP_PCADD: begin
							tgt_next = PC_W'(pc_reg + PC_W'(acc_in));
							state_next = SCU_ST_SECOND;
							ready_next = 1'b0;
						end
						scu_pkg::SCU_OP_RET_IMM, scu_pkg::SCU_OP_RET,
						scu_pkg::SCU_OP_RETI: begin
							if (op_code == scu_pkg::SCU_OP_RET_IMM) begin
								acc_next = op_imm;
								acc_we_next = 1'b1;
							end
							sp_next = scu_pkg::SP_W'(sp_reg -
								scu_pkg::SP_STEP);
							state_next = SCU_ST_SECOND;
							ready_next = 1'b0;
						end
						scu_pkg::SCU_OP_WDCLR: begin
							wdt_next = 1'b1;
							pc_next = pc_inc(pc_reg);
							done_next = 1'b1;
						end
						scu_pkg::SCU_OP_GIE_SET: begin
							gie_next = 1'b1;
							pc_next = pc_inc(pc_reg);
							done_next = 1'b1;
						end
						scu_pkg::SCU_OP_GIE_CLR: begin
							gie_next = 1'b0;
							pc_next = pc_inc(pc_reg);
							done_next = 1'b1;
						end
						scu_pkg::SCU_OP_FULL_HALT: begin
							full_next = 1'b1;
							pc_next = pc_inc(pc_reg);
							done_next = 1'b1;
							state_next = SCU_ST_HALT;
							ready_next = 1'b0;
						end
						scu_pkg::SCU_OP_CORE_HALT: begin
							core_next = 1'b1;
							pc_next = pc_inc(pc_reg);
							done_next = 1'b1;
							state_next = SCU_ST_HALT;
							ready_next = 1'b0;
						end
						scu_pkg::SCU_OP_SW_RESET: begin
							swr_next = 1'b1;
							done_next = 1'b1;
						end
						default: begin
							pc_next = pc_inc(pc_reg);
							done_next = 1'b1;
						end
					endcase
				end
			end
			SCU_ST_SECOND: begin
				unique case (op_reg)
					scu_pkg::SCU_OP_CALL: begin
						pc_next = tgt_reg;
						sp_next = scu_pkg::SP_W'(sp_reg +
							scu_pkg::SP_STEP);
					end
					scu_pkg::SCU_OP_RET_IMM, scu_pkg::SCU_OP_RET: begin
						pc_next = mem_rdata;
					end
					scu_pkg::SCU_OP_RETI: begin
						pc_next = mem_rdata;
						gie_next = 1'b1;
					end
					default: begin
						pc_next = tgt_reg;
					end
				endcase
				done_next = 1'b1;
				ready_next = 1'b1;
				state_next = SCU_ST_IDLE;
			end
			SCU_ST_HALT: begin
				// Wake-up lives outside; only a chip reset leaves this state.
				state_next = SCU_ST_HALT;
			end
			default: begin
				state_next = SCU_ST_IDLE;
			end
		endcase
	end

	// Flags pass through untouched by every operation here.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= SCU_ST_IDLE;
			op_reg <= scu_pkg::SCU_OP_NOP;
			pc_reg <= scu_pkg::PC_RESET;
			tgt_reg <= scu_pkg::PC_RESET;
			sp_reg <= scu_pkg::SP_RESET;
			acc_reg <= '0;
			acc_we_reg <= 1'b0;
			gie_reg <= 1'b0;
			wdt_reg <= 1'b0;
			full_reg <= 1'b0;
			core_reg <= 1'b0;
			swr_reg <= 1'b0;
			done_reg <= 1'b0;
			ready_reg <= 1'b1;
			flags_reg <= scu_pkg::FLAGS_RESET;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			pc_reg <= pc_next;
			tgt_reg <= tgt_next;
			sp_reg <= sp_next;
			acc_reg <= acc_next;
			acc_we_reg <= acc_we_next;
			gie_reg <= gie_next;
			wdt_reg <= wdt_next;
			full_reg <= full_next;
			core_reg <= core_next;
			swr_reg <= swr_next;
			done_reg <= done_next;
			ready_reg <= ready_next;
			flags_reg <= flags_in;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign op_ready = ready_reg;
	assign op_done = done_reg;
	assign pc = pc_reg;
	assign stack_pointer = sp_reg;
	assign acc_out = acc_reg;
	assign acc_we = acc_we_reg;
	assign flags_out = flags_reg;
	assign gie = gie_reg;
	assign wdt_clear = wdt_reg;
	assign full_halt = full_reg;
	assign core_halt = core_reg;
	assign sw_reset_req = swr_reg;

endmodule // scu_system_control

// file: tb/scu_checker.sv
`timescale 1ns/100ps
// ====
// Port checker
module scu_checker #(
	parameter int PC_W = 13,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic op_valid,
	input wire scu_pkg::scu_op_t op_code,
	input wire logic [PC_W-1:0] op_target,
	input wire logic [7:0] op_imm,
	input wire logic [7:0] acc_in,
	input wire logic [3:0] flags_in,
	input wire logic op_ready,
	input wire logic op_done,
	input wire logic [PC_W-1:0] pc,
	input wire logic [7:0] stack_pointer,
	input wire logic [7:0] acc_out,
	input wire logic acc_we,
	input wire logic [3:0] flags_out,
	input wire logic gie,
	input wire logic wdt_clear,
	input wire logic full_halt,
	input wire logic core_halt
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic tk;
	// A take needs both sides of the handshake.
	assign tk = op_valid && op_ready;
	call_push_a: assert property (tk && op_code == scu_pkg::SCU_OP_CALL
		|=> !op_ready ##1 op_done && pc == $past(op_target, 2)
		&& stack_pointer == 8'($past(stack_pointer, 2) + 2)) else $error("call");
	jump_abs_a: assert property (tk && op_code == scu_pkg::SCU_OP_GOTO
		|=> ##1 pc == $past(op_target, 2)
		&& stack_pointer == $past(stack_pointer, 2)) else $error("goto");
	ret_pop_a: assert property (tk && op_code inside {scu_pkg::SCU_OP_RET,
		scu_pkg::SCU_OP_RET_IMM, scu_pkg::SCU_OP_RETI}
		|=> stack_pointer == 8'($past(stack_pointer) - 2)) else $error("pop");
	ret_value_a: assert property (tk && op_code == scu_pkg::SCU_OP_RET_IMM
		|=> acc_we && acc_out == $past(op_imm)) else $error("ret imm");
	reti_gie_a: assert property (tk && op_code == scu_pkg::SCU_OP_RETI
		|=> ##1 op_done && gie) else $error("reti");
	wd_clear_a: assert property (tk && op_code == scu_pkg::SCU_OP_WDCLR
		|=> wdt_clear && $stable(gie) && pc == PC_W'($past(pc) + 1)) else $error("wd");
	pc_add_a: assert property (tk && op_code == scu_pkg::SCU_OP_PCADD
		|=> ##1 pc == PC_W'($past(pc, 2) + $past(acc_in, 2))) else $error("pcadd");
	gie_set_a: assert property (tk && op_code == scu_pkg::SCU_OP_GIE_SET
		|=> gie) else $error("gie set");
	gie_clr_a: assert property (tk && op_code == scu_pkg::SCU_OP_GIE_CLR
		|=> !gie) else $error("gie clr");
	full_stop_a: assert property (tk && op_code == scu_pkg::SCU_OP_FULL_HALT
		|=> full_halt && !op_ready) else $error("full halt");
	core_stop_a: assert property (tk && op_code == scu_pkg::SCU_OP_CORE_HALT
		|=> core_halt && !full_halt && !op_ready) else $error("core halt");
	// A reset edge loads the reset value, so only edges out of reset count.
	flags_keep_a: assert property (!rst
		|=> flags_out == $past(flags_in)) else $error("flags");
	nop_step_a: assert property (tk && op_code == scu_pkg::SCU_OP_NOP
		|=> op_done && pc == PC_W'($past(pc) + 1)) else $error("nop");
	cover property (tk && op_code == scu_pkg::SCU_OP_CALL);
	cover property (tk && op_code == scu_pkg::SCU_OP_RETI);
	cover property (tk && op_code == scu_pkg::SCU_OP_CORE_HALT);
endmodule // scu_checker

bind scu_system_control scu_checker #(.PC_W(PC_W), .DEPTH(DEPTH)) i_scu_checker (.*);

// file: tb/scu_rst_model.sv
`timescale 1ns/100ps
// ====
// Reset controller model
module scu_rst_model (
	input wire logic clk_sys,
	input wire logic por,
	input wire logic sw_reset_req,
	output logic rst
);
	logic rst_reg = 1'b1;
	logic rst_next;
	// A software request resets the chip just as power-on does.
	always_comb begin
		rst_next = por | sw_reset_req;
	end
	// Registered, so the request pulse is never cut by its own reset.
	always_ff @(posedge clk_sys) begin
		rst_reg <= rst_next;
	end
	assign rst = rst_reg;
endmodule // scu_rst_model

// file: tb/tb_scu_system_control.sv
`timescale 1ns/100ps
// ====
// Bench
module tb_scu_system_control;
	logic clk_sys = 0;
	logic por = 1;
	logic rst;
	logic op_valid = 0;
	scu_pkg::scu_op_t op_code = scu_pkg::SCU_OP_NOP;
	logic [12:0] op_target = 0;
	logic [7:0] op_imm = 0;
	logic [7:0] acc_in = 0;
	logic [3:0] flags_in = 4'h9;
	logic op_ready, op_done, acc_we, gie, wdt_clear;
	logic full_halt, core_halt, sw_reset_req;
	logic [12:0] pc;
	logic [7:0] stack_pointer, acc_out, acc_cap;
	logic [3:0] flags_out, ncyc;
	logic wd_seen, acc_seen;
	int num_errors = 0;
	int samples_checked = 0;
	scu_system_control i_scu_system_control (.*);
	scu_rst_model i_scu_rst_model (.*);
	always #10 clk_sys = ~clk_sys;
	// Compare without letting an unknown pass.
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// The extra edge keeps the first request off the releasing edge.
	task rst_chip;
		por = 1;
		repeat (4) @(negedge clk_sys);
		por = 0;
		repeat (2) @(negedge clk_sys);
	endtask
	// One operation; pulses are sampled in the cycle after the take.
	task op(input scu_pkg::scu_op_t c, input logic [12:0] t,
		input logic [7:0] a);
		@(negedge clk_sys);
		op_code = c;
		op_target = t;
		op_imm = a;
		acc_in = a;
		op_valid = 1;
		@(negedge clk_sys);
		op_valid = 0;
		ncyc = 1;
		wd_seen = wdt_clear;
		acc_seen = acc_we;
		acc_cap = acc_out;
		while (op_done !== 1'b1) begin
			if (ncyc == 4) begin
				num_errors++;
				summarize();
			end
			@(negedge clk_sys);
			ncyc++;
		end
	endtask
	task t_flow;
		rst_chip();
		op(scu_pkg::SCU_OP_GOTO, 13'h0100, 8'h00);
		chk(pc, 16'h0100);
		chk(stack_pointer, 16'h0000);
		chk(ncyc, 16'h0002);
		op(scu_pkg::SCU_OP_CALL, 13'h1FF0, 8'h00);
		chk(pc, 16'h1FF0);
		chk(stack_pointer, 16'h0002);
		op(scu_pkg::SCU_OP_CALL, 13'h0005, 8'h00);
		chk(stack_pointer, 16'h0004);
		op(scu_pkg::SCU_OP_RET_IMM, 13'h0000, 8'h5A);
		chk(acc_seen, 16'h0001);
		chk(acc_cap, 16'h005A);
		chk(pc, 16'h1FF1);
		op(scu_pkg::SCU_OP_RET, 13'h0000, 8'h00);
		chk(pc, 16'h0101);
		chk(stack_pointer, 16'h0000);
		chk(flags_out, 16'h0009);
		$display("test flow done");
	endtask
	task t_int;
		op(scu_pkg::SCU_OP_GIE_SET, 13'h0000, 8'h00);
		chk(gie, 16'h0001);
		chk(ncyc, 16'h0001);
		op(scu_pkg::SCU_OP_GIE_CLR, 13'h0000, 8'h00);
		chk(gie, 16'h0000);
		op(scu_pkg::SCU_OP_CALL, 13'h0400, 8'h00);
		op(scu_pkg::SCU_OP_RETI, 13'h0000, 8'h00);
		chk(gie, 16'h0001);
		chk(pc, 16'h0104);
		flags_in = 4'h6;
		op(scu_pkg::SCU_OP_PCADD, 13'h0000, 8'hFF);
		chk(pc, 16'h0203);
		chk(flags_out, 16'h0006);
		chk(ncyc, 16'h0002);
		$display("test interrupt done");
	endtask
	task t_misc;
		op(scu_pkg::SCU_OP_NOP, 13'h0000, 8'h00);
		chk(pc, 16'h0204);
		op(scu_pkg::SCU_OP_WDCLR, 13'h0000, 8'h00);
		chk(wd_seen, 16'h0001);
		chk(gie, 16'h0001);
		op(scu_pkg::SCU_OP_SW_RESET, 13'h0000, 8'h00);
		chk(sw_reset_req, 16'h0001);
		chk(pc, 16'h0205);
		repeat (3) @(negedge clk_sys);
		chk(pc, 16'h0000);
		chk(gie, 16'h0000);
		$display("test misc done");
	endtask
	// A halted core must ignore offered work until reset.
	task t_halt;
		op(scu_pkg::SCU_OP_CORE_HALT, 13'h0000, 8'h00);
		chk(core_halt, 16'h0001);
		chk(full_halt, 16'h0000);
		op_code = scu_pkg::SCU_OP_GIE_SET;
		op_valid = 1;
		repeat (3) @(negedge clk_sys);
		op_valid = 0;
		chk(gie, 16'h0000);
		rst_chip();
		op(scu_pkg::SCU_OP_FULL_HALT, 13'h0000, 8'h00);
		chk(full_halt, 16'h0001);
		chk(op_ready, 16'h0000);
		$display("test halt done");
	endtask
	initial begin
		t_flow();
		t_int();
		t_misc();
		t_halt();
		summarize();
	end
endmodule // tb_scu_system_control
